// file: src/flash_host_params.svh
// Purpose: Timing counts and pin layout constants for the flash bus controller.
// Assumes: 200 MHz clock, 5 ns period.
// Notes:   Times are in ns; cycle counts derive from them and round as marked.
`ifndef FLASH_HOST_PARAMS_SVH
`define FLASH_HOST_PARAMS_SVH

`define CLK_PERIOD_NS       5
// Address access time of the attached part, default for a mid speed grade.
`define ADDR_ACCESS_NS      90
// Least write strobe low time.
`define WRITE_PULSE_NS      35
// Least reset pulse width.
`define RESET_PULSE_MIN_NS  500
// Time from reset release to the first read.
`define RESET_TO_READ_NS    50
// Least rounds up.
`define ACCESS_CYC    ((`ADDR_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_CYC     ((`WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_PULSE_CYC ((`RESET_PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_READ_CYC  ((`RESET_TO_READ_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W         8

`define SECTOR_BIT_A6 6
`define SECTOR_BIT_A1 1
`define SECTOR_BIT_A0 0
`define UNLOCK1_ADDR  22'h00_0555
`define UNLOCK2_ADDR  22'h00_02AA
`define UNLOCK1_DATA  16'h00AA
`define UNLOCK2_DATA  16'h0055
`define PROG_CMD      16'h00A0

`endif

// file: src/flash_host_pkg.sv
// Purpose: Types shared by the flash bus controller files.
// Assumes: Constants come from flash_host_params.svh.
// Notes:   None.
package flash_host_pkg;

  typedef enum logic [2:0] {
    op_read,
    op_write,
    op_bypass_prog,
    op_protect,
    op_unprotect,
    op_reset
  } op_t;

  typedef struct packed {
    op_t         op;
    logic [21:0] addr;
    logic [15:0] data;
  } req_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic reset_n;
    logic protect_hv;
    logic accel_hv;
    logic accel_n;
  } strobes_t;

endpackage

// file: src/flash_pin_sync.sv
// Purpose: Two flip-flop synchroniser for pin inputs.
// Assumes: One clock domain.
// Notes:   The first stage feeds only the second.
`timescale 1ns/1ps
module flash_pin_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         nrst,
  // Data.
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb begin
    next_meta = d;
    next_q    = meta;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= next_meta;
      q    <= next_q;
    end
  end
endmodule

// file: src/flash_host_ctrl.sv
// Purpose: Host-side controller driving a parallel NOR flash through its pins.
// Assumes: One request at a time; the flash is asynchronous to clk.
// Notes:   High voltage levels are shown as enable outputs for an external switch.
//
// Contract
// - Read: chip select and output gate low, write strobe and reset high.
// - Write: write strobe and chip select low, output gate high.
// - Unlock bypass programs with two write cycles instead of four.
// - Host applies accelerate level only for bypass programming.
// - Host reissues an operation that reset interrupted; the controller only pulses rsp_valid after reset.
// - Host waits reset-to-read time after releasing reset.
// - Protect: select, write low, reset high voltage, A6 picks protect.
`timescale 1ns/1ps
`include "flash_host_params.svh"
module flash_host_ctrl
  import flash_host_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        nrst,
  // Request side.
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire req_t        req,
  input  wire logic        byte_mode,
  output logic             rsp_valid,
  output logic [15:0]      rsp_data,
  output logic             busy,
  // Flash pins.
  output logic [21:0]      addr,
  output logic [15:0]      dq_out,
  output logic [15:0]      dq_oe,
  input  wire logic [15:0] dq_in,
  output strobes_t         pins,
  output logic             width_select_n,
  input  wire logic        ready_busy_n
);

  typedef enum logic [2:0] {
    st_idle,
    st_setup,
    st_strobe,
    st_hold,
    st_rst_low,
    st_rst_wait,
    st_bypass2
  } state_t;

  state_t               state;
  state_t               next_state;
  req_t                 cur;
  req_t                 next_cur;
  logic [`CNT_W-1:0]    cnt;
  logic [`CNT_W-1:0]    next_cnt;
  strobes_t             next_pins;
  logic [15:0]          next_rsp_data;
  logic                 next_rsp_valid;
  logic [15:0]          next_dq_out;
  logic                 drive;
  logic                 next_drive;
  logic [15:0]          dq_sync;
  logic                 rb_sync;

  flash_pin_sync #(.W(17)) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .d    ({ready_busy_n, dq_in}),
    .q    ({rb_sync, dq_sync})
  );

  // Pick the data pins to drive: byte mode leaves the upper lanes undriven here; lane 15 is added below.
  function automatic logic [15:0] lane_enable(input logic bm, input logic en);
    lane_enable = en ? (bm ? 16'h00FF : 16'hFFFF) : 16'h0000;
  endfunction

  function automatic logic is_write(input op_t o);
    is_write = (o != op_read) && (o != op_reset);
  endfunction

  assign width_select_n = !byte_mode;
  assign req_ready      = (state == st_idle);
  assign busy           = !rb_sync;
  // Upper lane 15 carries the lowest address bit in byte mode.
  assign dq_oe          = lane_enable(byte_mode, drive) |
                          (byte_mode ? 16'h8000 : 16'h0000);

  always_comb begin
    next_state     = state;
    next_cur       = cur;
    next_cnt       = cnt;
    next_pins      = pins;
    next_rsp_valid = 1'b0;
    next_rsp_data  = rsp_data;
    next_dq_out    = dq_out;
    next_drive     = drive;
    case (state)
      st_idle: begin
        // Standby between cycles: select and reset high.
        next_pins.ce_n       = 1'b1;
        next_pins.oe_n       = 1'b1;
        next_pins.we_n       = 1'b1;
        next_pins.protect_hv = 1'b0;
        next_pins.accel_hv   = 1'b0;
        next_drive           = 1'b0;
        if (req_valid) begin
          next_cur = req;
          next_cnt = '0;
          if (req.op == op_reset) begin
            next_pins.reset_n = 1'b0;
            next_state        = st_rst_low;
          end else begin
            next_pins.ce_n       = 1'b0;
            next_pins.protect_hv = (req.op == op_protect) ||
                                   (req.op == op_unprotect);
            next_pins.accel_hv   = (req.op == op_bypass_prog);
            next_dq_out          = (req.op == op_bypass_prog) ? `PROG_CMD : req.data;
            next_drive           = is_write(req.op);
            next_state           = st_setup;
          end
        end
      end
      st_setup: begin
        if (cur.op == op_read) begin
          next_pins.oe_n = 1'b0;
        end else begin
          next_pins.we_n = 1'b0;
        end
        next_cnt   = '0;
        next_state = st_strobe;
      end
      st_strobe: begin
        next_cnt = cnt + `CNT_W'(1);
        if (cur.op == op_read && cnt == `CNT_W'(`ACCESS_CYC + 2)) begin
          next_rsp_data  = byte_mode ? {8'h00, dq_sync[7:0]} : dq_sync;
          next_rsp_valid = 1'b1;
          next_pins.oe_n = 1'b1;
          next_state     = st_hold;
        end else if (cur.op != op_read && cnt == `CNT_W'(`WRITE_CYC - 1)) begin
          next_pins.we_n = 1'b1;
          next_state     = st_hold;
        end
      end
      st_hold: begin
        // The first bypass cycle keeps its op; the second one runs as a plain write.
        if (cur.op == op_bypass_prog && drive) begin
          // Second of the two bypass cycles carries the program data.
          next_dq_out = cur.data;
          next_state  = st_bypass2;
        end else begin
          next_pins.ce_n = 1'b1;
          next_drive     = 1'b0;
          next_state     = st_idle;
        end
      end
      st_bypass2: begin
        next_dq_out = cur.data;
        next_state  = st_setup;
        next_cur.op = op_write;
      end
      st_rst_low: begin
        next_cnt = cnt + `CNT_W'(1);
        if (cnt == `CNT_W'(`RST_PULSE_CYC - 1)) begin
          next_pins.reset_n = 1'b1;
          next_cnt          = '0;
          next_state        = st_rst_wait;
        end
      end
      st_rst_wait: begin
        next_cnt = cnt + `CNT_W'(1);
        // Wait both the read recovery time and for the busy line to clear.
        if (cnt >= `CNT_W'(`RST_READ_CYC - 1) && rb_sync) begin
          // This pulse tells the requester that an interrupted operation may be reissued.
          next_rsp_valid = 1'b1;
          next_state     = st_idle;
        end
      end
      default: next_state = st_idle;
    endcase
    // Applied after the case so that a freshly taken request also gets its lane 15 right.
    if (byte_mode) begin
      next_dq_out[15] = next_cur.addr[0];
    end
    next_pins.accel_n = !next_pins.accel_hv;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state     <= st_idle;
      cur       <= '0;
      cnt       <= '0;
      pins      <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b1,
                     protect_hv: 1'b0, accel_hv: 1'b0, accel_n: 1'b1};
      rsp_valid <= 1'b0;
      rsp_data  <= '0;
      dq_out    <= '0;
      drive     <= 1'b0;
    end else begin
      state     <= next_state;
      cur       <= next_cur;
      cnt       <= next_cnt;
      pins      <= next_pins;
      rsp_valid <= next_rsp_valid;
      rsp_data  <= next_rsp_data;
      dq_out    <= next_dq_out;
      drive     <= next_drive;
    end
  end

  assign addr = (cur.op == op_protect || cur.op == op_unprotect) ?
                {cur.addr[21:7], cur.op == op_unprotect, cur.addr[5:2], 2'b10} :
                cur.addr;

  a_read_no_write: assert property (@(posedge clk) disable iff (!nrst)
    !pins.oe_n |-> pins.we_n && pins.reset_n && !pins.ce_n)
    else $error("Output gate low without a clean read.");
  a_write_no_gate: assert property (@(posedge clk) disable iff (!nrst)
    !pins.we_n |-> pins.oe_n && !pins.ce_n)
    else $error("Write strobe low with output gate low.");
  a_no_fight: assert property (@(posedge clk) disable iff (!nrst)
    !pins.oe_n |-> (dq_oe & 16'h7FFF) == 16'h0000)
    else $error("Host drives data while flash outputs.");
  a_accel_only: assert property (@(posedge clk) disable iff (!nrst)
    pins.accel_hv |-> cur.op == op_bypass_prog || cur.op == op_write)
    else $error("Accelerate level outside programming.");
  a_reset_width: assert property (@(posedge clk) disable iff (!nrst)
    $fell(pins.reset_n) |-> !pins.reset_n [*8])
    else $error("Reset pulse too short.");
  a_reset_read: assert property (@(posedge clk) disable iff (!nrst)
    $rose(pins.reset_n) |-> pins.oe_n [*8])
    else $error("Read too soon after reset.");
  a_protect_addr: assert property (@(posedge clk) disable iff (!nrst)
    pins.protect_hv && !pins.we_n |-> addr[1] && !addr[0])
    else $error("Protect address bits wrong.");
  a_byte_lanes: assert property (@(posedge clk) disable iff (!nrst)
    byte_mode |-> dq_oe[14:8] == 7'h00)
    else $error("Upper lanes driven in byte mode.");
endmodule

// file: dv/flash_dev_model.sv
// Purpose: Behavioural flash device as seen from its pins.
// Assumes: clk paces the busy timing and the released data lines; the part itself has no clock.
// Notes:   Released data lines show the inverse of their last value.
`timescale 1ns/1ps
module flash_dev_model
  import flash_host_pkg::*;
(
  // Clock.
  input  wire logic        clk,
  // Pins.
  input  wire logic [21:0] addr,
  input  wire strobes_t    pins,
  input  wire logic        width_select_n,
  output logic [15:0]      dq_in,
  output logic             ready_busy_n
);
  // ==========================================================
  // Read path
  logic [15:0] last = 16'h0000;
  logic [15:0] rd;
  logic        drv;
  logic        we_q = 1'b1;
  logic [7:0]  busy_cnt = 8'h00;
  // Data follows the address pins directly, so it holds while they rest.
  assign rd  = {addr[7:0] ^ 8'h5a, addr[15:8]};
  assign drv = !pins.ce_n && !pins.oe_n && pins.we_n && pins.reset_n;
  always_comb begin
    dq_in = ~last;
    if (drv && width_select_n) dq_in = rd;
    else if (drv) dq_in[7:0] = rd[7:0];
  end
  always @(posedge clk) last <= dq_in;
  // ==========================================================
  // Busy line
  // A write that ends is taken as a started program, but only while selected.
  always @(posedge clk) begin
    we_q <= pins.we_n;
    if (!pins.reset_n && busy_cnt != 8'h00) busy_cnt <= 8'h14;
    else if (pins.we_n && !we_q && !pins.ce_n) busy_cnt <= 8'h28;
    else if (busy_cnt != 8'h00) busy_cnt <= busy_cnt - 8'h01;
  end
  assign ready_busy_n = (busy_cnt == 8'h00);
endmodule

// file: dv/flash_bus_operation_control_bench.sv
// Purpose: Self-checking bench for flash_host_ctrl against a device model.
// Assumes: 200 MHz clock; inputs change on the falling edge.
// Notes:   Expected reads and writes are queued and popped as they appear.
`timescale 1ns/1ps
module flash_bus_operation_control_bench
  import flash_host_pkg::*;
;
  logic        clk, nrst, req_valid, req_ready, byte_mode, rsp_valid, busy;
  logic        width_select_n, ready_busy_n;
  req_t        req;
  strobes_t    pins;
  logic [21:0] addr, a;
  logic [15:0] rsp_data, dq_out, dq_oe, dq_in, rq[$], rm[$];
  logic [40:0] wq[$], wm[$];
  int          err_total, comparisons;

  flash_host_ctrl DUT (.clk(clk), .nrst(nrst), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .byte_mode(byte_mode), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .busy(busy), .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in), .pins(pins),
    .width_select_n(width_select_n), .ready_busy_n(ready_busy_n));
  flash_dev_model flash (.clk(clk), .addr(addr), .pins(pins),
    .width_select_n(width_select_n), .dq_in(dq_in), .ready_busy_n(ready_busy_n));

  // ==========================================================
  // Checking
  task automatic check(input logic [40:0] got, input logic [40:0] exp, input logic [40:0] msk);
    comparisons++;
    if ((got & msk) !== (exp & msk)) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got & msk, exp & msk);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Sampled on the falling edge, where the one-cycle pulse is settled.
  always @(negedge clk) if (nrst && rsp_valid === 1'b1) begin
    if (rq.size() == 0) check(41'h1, 41'h0, 41'h1);
    else check({25'h0, rsp_data}, {25'h0, rq.pop_front()}, {25'h0, rm.pop_front()});
  end
  // Writes are judged at the rising write strobe, where the part latches them.
  always @(posedge pins.we_n) if (nrst && pins.ce_n === 1'b0) begin
    if (wq.size() == 0) check(41'h1, 41'h0, 41'h1);
    else check({pins.oe_n, pins.protect_hv, pins.accel_hv, addr, dq_out},
               wq.pop_front(), wm.pop_front());
  end

  // ==========================================================
  // Stimulus
  task automatic issue(input op_t op, input logic [21:0] ad, input logic [15:0] d);
    int n;
    n = 0;
    @(negedge clk);
    while (req_ready !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (req_ready !== 1'b1) check(41'h1, 41'h0, 41'h1);
    req_valid = 1'b1;
    req = '{op, ad, d};
    @(negedge clk);
    req_valid = 1'b0;
  endtask
  task automatic do_read(input logic [21:0] ad);
    rq.push_back({ad[7:0] ^ 8'h5a, ad[15:8]});
    rm.push_back(byte_mode ? 16'h00ff : 16'hffff);
    issue(op_read, ad, 16'h0000);
  endtask
  task automatic expect_wr(input logic [40:0] e, input logic [40:0] m);
    wq.push_back(e);
    wm.push_back(m);
  endtask
  // Waits until every queued result has appeared and the controller is idle again.
  task automatic settle();
    int n;
    n = 0;
    while ((rq.size() != 0 || wq.size() != 0 || req_ready !== 1'b1) && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 3000) check(41'h1, 41'h0, 41'h1);
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
  initial begin
    nrst = 1'b0; req_valid = 1'b0; req = '0; byte_mode = 1'b0;
    err_total = 0; comparisons = 0;
    void'($urandom(32'h3ddb));
    repeat (20) @(posedge clk);
    @(negedge clk) nrst = 1'b1;
    for (int m = 0; m < 2; m++) begin
      settle();
      byte_mode = m[0];
      @(negedge clk);
      check({25'h0, dq_oe}, {25'h0, m[0] ? 16'h8000 : 16'h0000}, {25'h0, 16'hffff});
      check({40'h0, width_select_n}, {40'h0, ~m[0]}, 41'h1);
      do_read(22'h00_0000);
      do_read(22'h3f_ffff);
      for (int i = 0; i < 3; i++) do_read(22'($urandom()));
      // A byte-mode write must carry the low address bit on lane 15.
      a = 22'($urandom());
      req.data = 16'($urandom());
      expect_wr({3'b100, a, (m[0] ? {a[0], req.data[14:0]} : req.data)},
                {3'b111, 22'h3f_ffff, (m[0] ? 16'h80ff : 16'hffff)});
      issue(op_write, a, req.data);
    end
    settle();
    byte_mode = 1'b0;
    for (int i = 0; i < 3; i++) begin
      a = 22'($urandom());
      req.data = 16'($urandom());
      expect_wr({3'b100, a, req.data}, '1);
      issue(op_write, a, req.data);
    end
    a = 22'($urandom());
    expect_wr({3'b101, 22'h0, 16'h00a0}, {3'b111, 22'h0, 16'hffff});
    expect_wr({3'b101, a, 16'h1234}, '1);
    issue(op_bypass_prog, a, 16'h1234);
    expect_wr({3'b110, 22'h2, 16'h0}, {3'b111, 22'h43, 16'h0});
    issue(op_protect, 22'h1f_8000, 16'h0000);
    expect_wr({3'b110, 22'h42, 16'h0}, {3'b111, 22'h43, 16'h0});
    issue(op_unprotect, 22'h1f_8000, 16'h0000);
    // Reset lands while the model is still busy with this program.
    expect_wr({3'b100, 22'h00_0123, 16'hbeef}, '1);
    issue(op_write, 22'h00_0123, 16'hbeef);
    rq.push_back(16'h0000);
    rm.push_back(16'h0000);
    issue(op_reset, 22'h0, 16'h0000);
    repeat (3) @(negedge clk);
    check({40'h0, busy}, 41'h1, 41'h1);
    settle();
    check({40'h0, busy}, 41'h0, 41'h1);
    do_read(22'h2a_5a5a);
    settle();
    report_and_stop();
  end
endmodule
